// ---- oau_decoder.sv ----
// Purpose: addressing-mode decode and operand/target address formation
// Assumes: bytes arrive one per strobe in instruction order with their address
// Notes: pointer and index contents are supplied by the register file outside

// ------------------------------------------------------------------
// module
// ------------------------------------------------------------------
// What this block does
// - register-to-register load takes source and destination fields from opcode bits
// - arithmetic ops imply accumulator destination; only other operand encoded
// - immediate mode uses the byte after opcode as data
// - immediate extended builds 16-bit value from two following bytes
// - direct mode forms 16-bit address from two instruction bytes
// - absolute jump loads program counter with bytes two and three
// - register indirect uses named 16-bit pair contents as address
// - one-byte add from pointer pair implies accumulator and pointer pair
// - indexed address is index register plus instruction displacement
// - relative jumps target program counter plus instruction displacement
// - restart is one byte calling one of eight page-zero locations
// - restart target equals opcode index times eight
// - ordinary call is three bytes with direct 16-bit target
// - bit mode selects one bit of register or memory byte
// - ten addressing modes, each limited to instructions that allow it
// - displacements are signed 8-bit two's complement
// - 3-bit register code 000 is B, 111 is accumulator
module oau_decoder import oau_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // instruction byte stream
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [15:0] byte_addr,
  // register contents from the core
  input wire logic [15:0] primary_pointer_pair,
  input wire logic [15:0] pair_bc,
  input wire logic [15:0] pair_de,
  input wire logic [15:0] index_reg_x,
  input wire logic [15:0] index_reg_y,
  // decoded operand
  output oau_out_t dec_out
);

  typedef struct packed {
    oau_state_t st;
    oau_ctx_t ctx;
    oau_out_t o;
  } oau_all_t;

  oau_all_t r, next_r;
  logic [15:0] disp;
  logic [15:0] word;
  logic [15:0] idx_base;

  assign disp = {{8{byte_data[7]}}, byte_data};
  assign word = {byte_data, r.ctx.lo};
  assign idx_base = (r.ctx.pfx == OAU_PFX_Y) ? index_reg_y : index_reg_x;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.o.valid = 1'b0;
    next_r.o.load_pc = 1'b0;
    next_r.o.addr_valid = 1'b0;
    if (byte_valid) begin
      case (r.st)
        OAU_S_OP: begin
          next_r.ctx.pc = byte_addr;
          next_r.ctx.opc = byte_data;
          next_r.ctx.pfx = 8'h00;
          next_r.o = '0;
          next_r.o.src_sel = byte_data[OAU_SRC_LSB +: 3];
          next_r.o.dst_sel = byte_data[OAU_DST_LSB +: 3];
          if (byte_data == OAU_PFX_X || byte_data == OAU_PFX_Y || byte_data == OAU_PFX_ED) begin
            next_r.ctx.pfx = byte_data;
            next_r.st = OAU_S_OP2;
          end else if (byte_data == OAU_PFX_CB) begin
            next_r.st = OAU_S_CB;
          end else if (byte_data == OAU_OP_JABS || byte_data == OAU_OP_CALL ||
                       byte_data == OAU_OP_ALOAD || byte_data == OAU_OP_STAN ||
                       (byte_data[7:6] == 2'h0 && byte_data[3:0] == 4'h1)) begin
            next_r.st = OAU_S_B1;
          end else if (byte_data == OAU_OP_JREL ||
                       (byte_data[7:6] == 2'h0 && byte_data[2:0] == 3'h6)) begin
            next_r.st = OAU_S_B2;
          end else if (byte_data[7:6] == 2'h1 && byte_data[5:3] != OAU_REG_MEM &&
                       byte_data[2:0] != OAU_REG_MEM) begin
            next_r.o.mode = 4'(OAU_M_REG);
            next_r.o.valid = 1'b1;
          end else if (byte_data[7:6] == 2'h2 && byte_data[2:0] == OAU_REG_MEM) begin
            next_r.o.mode = 4'(OAU_M_IND);
            next_r.o.dst_sel = OAU_REG_A;
            next_r.o.pair_sel = OAU_PAIR_PTR;
            next_r.o.addr = primary_pointer_pair;
            next_r.o.addr_valid = 1'b1;
            next_r.o.valid = 1'b1;
          end else if (byte_data[7:6] == 2'h2) begin
            next_r.o.mode = 4'(OAU_M_IMPL);
            next_r.o.dst_sel = OAU_REG_A;
            next_r.o.valid = 1'b1;
          end else if (byte_data[7:6] == 2'h3 && byte_data[2:0] == 3'h7) begin
            next_r.o.mode = 4'(OAU_M_PAGE0);
            next_r.o.new_pc = OAU_RST_BASE | (16'(byte_data[5:3]) << OAU_RST_SHIFT);
            next_r.o.load_pc = 1'b1;
            next_r.o.valid = 1'b1;
          end else if (byte_data[7:6] == 2'h0 && byte_data[5] == 1'b0 && byte_data[2:0] == 3'h2) begin
            next_r.o.mode = 4'(OAU_M_IND);
            next_r.o.pair_sel = byte_data[5:4];
            next_r.o.addr = (byte_data[4]) ? pair_de : pair_bc;
            next_r.o.addr_valid = 1'b1;
            next_r.o.valid = 1'b1;
          end else begin
            next_r.o.mode = 4'(OAU_M_NONE);
            next_r.o.valid = 1'b1;
          end
        end
        OAU_S_OP2: begin
          next_r.ctx.opc = byte_data;
          next_r.o.src_sel = byte_data[2:0];
          next_r.o.dst_sel = byte_data[5:3];
          next_r.o.idx_sel = (r.ctx.pfx == OAU_PFX_Y) ? 2'h1 : 2'h0;
          if (r.ctx.pfx == OAU_PFX_ED) begin
            next_r.o.mode = 4'(OAU_M_REG);
            next_r.o.valid = 1'b1;
            next_r.st = OAU_S_OP;
          end else if (byte_data == OAU_OP_XWORD) begin
            next_r.st = OAU_S_B1;
          end else if (byte_data == OAU_PFX_CB || byte_data == OAU_OP_INCM ||
                       byte_data[2:0] == OAU_REG_MEM || byte_data[7:3] == 5'h0E) begin
            next_r.st = OAU_S_B2;
          end else begin
            next_r.o.mode = 4'(OAU_M_NONE);
            next_r.o.valid = 1'b1;
            next_r.st = OAU_S_OP;
          end
        end
        OAU_S_B1: begin
          next_r.ctx.lo = byte_data;
          next_r.st = OAU_S_B2;
        end
        OAU_S_B2: begin
          next_r.st = OAU_S_OP;
          next_r.o.valid = 1'b1;
          if (r.ctx.pfx != 8'h00) begin
            if (r.ctx.opc == OAU_OP_XWORD) begin
              next_r.o.mode = 4'(OAU_M_IMMX);
              next_r.o.data16 = word;
            end else begin
              next_r.o.mode = 4'(OAU_M_IDX);
              next_r.o.addr = idx_base + disp;
              next_r.o.addr_valid = 1'b1;
              if (r.ctx.opc == OAU_PFX_CB) begin
                // address kept, no strobe yet: the bit opcode still follows
                next_r.o.addr_valid = 1'b0;
                next_r.o.valid = 1'b0;
                next_r.st = OAU_S_CB;
              end
            end
          end else if (r.ctx.opc == OAU_OP_JREL) begin
            next_r.o.mode = 4'(OAU_M_REL);
            next_r.o.new_pc = r.ctx.pc + OAU_JR_LEN + disp;
            next_r.o.load_pc = 1'b1;
          end else if (r.ctx.opc[7:6] == 2'h0 && r.ctx.opc[2:0] == 3'h6) begin
            next_r.o.mode = 4'(OAU_M_IMM);
            next_r.o.data8 = byte_data;
          end else if (r.ctx.opc[3:0] == 4'h1 && r.ctx.opc[7:6] == 2'h0) begin
            next_r.o.mode = 4'(OAU_M_IMMX);
            next_r.o.pair_sel = r.ctx.opc[5:4];
            next_r.o.data16 = word;
          end else begin
            next_r.o.mode = 4'(OAU_M_DIR);
            next_r.o.addr = word;
            next_r.o.addr_valid = 1'b1;
            next_r.o.load_pc = (r.ctx.opc == OAU_OP_JABS || r.ctx.opc == OAU_OP_CALL);
            next_r.o.new_pc = word;
          end
        end
        OAU_S_CB: begin
          next_r.st = OAU_S_OP;
          next_r.o.valid = 1'b1;
          next_r.o.mode = 4'(OAU_M_BIT);
          next_r.o.bit_sel = byte_data[5:3];
          next_r.o.src_sel = byte_data[2:0];
          if (r.ctx.pfx == 8'h00 && byte_data[2:0] == OAU_REG_MEM) begin
            next_r.o.addr = primary_pointer_pair;
            next_r.o.addr_valid = 1'b1;
          end else if (r.ctx.pfx != 8'h00) begin
            next_r.o.addr_valid = 1'b1;
          end
        end
        default: next_r.st = OAU_S_OP;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r.st <= OAU_S_OP;
      r.ctx <= '0;
      r.ctx.pc <= OAU_RESET_PC;
      r.o <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign dec_out = r.o;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_restart_vector: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_valid && r.st == OAU_S_OP && byte_data[7:6] == 2'h3 && byte_data[2:0] == 3'h7)
    |=> (dec_out.load_pc && dec_out.new_pc == {10'h000, $past(byte_data[5:3]), 3'h0}))
    else $error("restart vector wrong");
  chk_reg_fields: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_valid && r.st == OAU_S_OP && byte_data == 8'h41)
    |=> (dec_out.mode == 4'(OAU_M_REG) && dec_out.dst_sel == 3'h0 && dec_out.src_sel == 3'h1))
    else $error("register fields wrong");
  chk_implied_acc: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_valid && r.st == OAU_S_OP && byte_data == 8'h82)
    |=> (dec_out.dst_sel == OAU_REG_A && dec_out.src_sel == 3'h2))
    else $error("implied accumulator wrong");
  chk_add_pointer: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_valid && r.st == OAU_S_OP && byte_data == 8'h86)
    |=> (dec_out.valid && dec_out.addr == $past(primary_pointer_pair)))
    else $error("pointer add wrong");
  chk_rel_target: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_valid && r.st == OAU_S_OP && byte_data == OAU_OP_JREL)
    ##1 (byte_valid && r.st == OAU_S_B2 && byte_data == 8'h05)
    |=> (dec_out.new_pc == $past(r.ctx.pc) + 16'h0007))
    else $error("relative target wrong");
  chk_abs_jump: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_valid && r.st == OAU_S_OP && byte_data == OAU_OP_JABS)
    ##1 (byte_valid && r.st == OAU_S_B1 && byte_data == 8'h77)
    ##1 (byte_valid && byte_data == 8'h03)
    |=> (dec_out.load_pc && dec_out.new_pc == 16'h0377))
    else $error("absolute jump wrong");
  chk_imm_byte: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_valid && r.st == OAU_S_OP && byte_data == 8'h1E)
    ##1 (byte_valid && r.st == OAU_S_B2)
    |=> (dec_out.mode == 4'(OAU_M_IMM) && dec_out.data8 == $past(byte_data)))
    else $error("immediate byte wrong");
  chk_one_byte: assert property (@(posedge clk) disable iff (!rst_b)
    (byte_valid && r.st == OAU_S_OP && byte_data[7:6] == 2'h3 && byte_data[2:0] == 3'h7)
    |=> (r.st == OAU_S_OP && dec_out.new_pc[15:8] == 8'h00))
    else $error("restart not single byte");

endmodule

// ---- oau_pkg.sv ----
// Purpose: shared types and constants for the operand addressing unit
// Assumes: single 40 MHz clock, synchronous active-low reset
// Notes: opcode field positions and vectors are defined here; the decoder also slices opcode bits directly
package oau_pkg;

  // --------------------------------------------------------------
  // opcode fields
  // --------------------------------------------------------------
  localparam int OAU_DST_LSB = 3;
  localparam int OAU_SRC_LSB = 0;
  localparam logic [2:0] OAU_REG_B = 3'h0;
  localparam logic [2:0] OAU_REG_MEM = 3'h6;
  localparam logic [2:0] OAU_REG_A = 3'h7;
  localparam logic [1:0] OAU_PAIR_PTR = 2'h2;
  localparam logic [7:0] OAU_PFX_CB = 8'hCB;
  localparam logic [7:0] OAU_PFX_X = 8'hDD;
  localparam logic [7:0] OAU_PFX_Y = 8'hFD;
  localparam logic [7:0] OAU_PFX_ED = 8'hED;
  localparam logic [7:0] OAU_OP_JABS = 8'hC3;
  localparam logic [7:0] OAU_OP_CALL = 8'hCD;
  localparam logic [7:0] OAU_OP_JREL = 8'h18;
  localparam logic [7:0] OAU_OP_XWORD = 8'h21;
  localparam logic [7:0] OAU_OP_ALOAD = 8'h3A;
  localparam logic [7:0] OAU_OP_STAN = 8'h32;
  localparam logic [7:0] OAU_OP_INCM = 8'h34;
  localparam logic [15:0] OAU_RST_BASE = 16'h0000;
  localparam int OAU_RST_SHIFT = 3;
  localparam logic [15:0] OAU_JR_LEN = 16'h0002;
  localparam logic [15:0] OAU_RESET_PC = 16'h0000;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum {
    OAU_M_NONE, OAU_M_REG, OAU_M_IMPL, OAU_M_IMM, OAU_M_IMMX,
    OAU_M_DIR, OAU_M_IND, OAU_M_IDX, OAU_M_REL, OAU_M_PAGE0, OAU_M_BIT
  } oau_mode_t;

  typedef enum {OAU_S_OP, OAU_S_OP2, OAU_S_B1, OAU_S_B2, OAU_S_CB} oau_state_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] opc;
    logic [7:0] pfx;
    logic [7:0] lo;
  } oau_ctx_t;

  typedef struct packed {
    logic valid;
    logic [3:0] mode;
    logic [2:0] dst_sel;
    logic [2:0] src_sel;
    logic [1:0] pair_sel;
    logic [1:0] idx_sel;
    logic [2:0] bit_sel;
    logic [7:0] data8;
    logic [15:0] data16;
    logic [15:0] addr;
    logic addr_valid;
    logic load_pc;
    logic [15:0] new_pc;
  } oau_out_t;

endpackage

// ---- oau_prog_mem.sv ----
// Purpose: program memory model that feeds instruction bytes to the decoder
// Assumes: bytes change at the falling clock edge, one per cycle or spaced
// Notes: each idle cycle inverts the previous bus value, so a second idle cycle shows the byte again
module oau_prog_mem (
  // clock
  input wire logic clk,
  // byte stream toward the decoder
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic [15:0] byte_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // storage and fetch
  // ------------------------------------------------------------
  logic [7:0] mem [0:65535];

  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    byte_addr = 16'h0000;
  end

  // gap idles the bus between bytes, as a slow memory would
  task automatic fetch(input logic [15:0] start, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      byte_valid = 1'b1;
      byte_data = mem[start + 16'(i)];
      byte_addr = start + 16'(i);
      for (int g = 0; g < gap && i < n - 1; g++) begin
        @(negedge clk);
        byte_valid = 1'b0;
        byte_data = ~byte_data;
        byte_addr = ~byte_addr;
      end
    end
    @(negedge clk);
    byte_valid = 1'b0;
    byte_data = ~byte_data;
    byte_addr = ~byte_addr;
  endtask
endmodule

// ---- operand_addressing_unit_tb.sv ----
// Purpose: self-checking bench for the operand addressing decoder
// Assumes: inputs change at the falling edge, outputs sampled there
// Notes: each scenario loads code into the memory model and fetches it
module operand_addressing_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import oau_pkg::*;

  // ------------------------------------------------------------
  // clock, reset, wiring
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic byte_valid;
  logic [7:0] byte_data;
  logic [15:0] byte_addr;
  logic [15:0] ptr_pair = 16'h0254;
  logic [15:0] bc = 16'h1111;
  logic [15:0] de = 16'h2222;
  logic [15:0] idx_x = 16'h2000;
  logic [15:0] idx_y = 16'h1000;
  oau_out_t dec_out;
  oau_out_t res;
  int failures = 0;
  int num_checks = 0;

  always #12.5 clk = ~clk;

  oau_prog_mem i_oau_prog_mem (.clk(clk), .byte_valid(byte_valid), .byte_data(byte_data), .byte_addr(byte_addr));
  oau_decoder i_oau_decoder (.clk(clk), .rst_b(rst_b), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_addr(byte_addr), .primary_pointer_pair(ptr_pair), .pair_bc(bc), .pair_de(de), .index_reg_x(idx_x),
    .index_reg_y(idx_y), .dec_out(dec_out));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // code is packed first byte highest; result captured in its valid cycle
  task automatic run(input logic [15:0] a, input logic [31:0] code, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      i_oau_prog_mem.mem[a + 16'(i)] = code[8 * (n - 1 - i) +: 8];
    end
    i_oau_prog_mem.fetch(a, n, gap);
    res = dec_out;
    check(16'(res.valid), 16'h0001);
    @(negedge clk);
    // pulses must drop after one cycle
    check({13'h0000, dec_out.valid, dec_out.addr_valid, dec_out.load_pc}, 16'h0000);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_register;
    run(16'h0010, 32'h0000_0041, 1, 0);
    check(16'(res.mode), 16'(OAU_M_REG));
    check(16'({res.dst_sel, 1'b0, res.src_sel}), 16'({3'h0, 1'b0, 3'h1}));
    run(16'h0011, 32'h0000_0078, 1, 0);
    check(16'({res.dst_sel, 1'b0, res.src_sel}), 16'({3'h7, 1'b0, 3'h0}));
    run(16'h0012, 32'h0000_0082, 1, 0);
    check(16'(res.mode), 16'(OAU_M_IMPL));
    check(16'({res.dst_sel, 1'b0, res.src_sel}), 16'({3'h7, 1'b0, 3'h2}));
    run(16'h0013, 32'h0000_ED4D, 2, 0);
    check(16'(res.mode), 16'(OAU_M_REG));
    run(16'h0015, 32'h0000_0000, 1, 0);
    check(16'(res.mode), 16'(OAU_M_NONE));
    $display("done register and implied");
  endtask

  task automatic t_immediate;
    run(16'h0020, 32'h0000_1E7C, 2, 0);
    check({res.mode, 4'h0, res.data8}, {4'(OAU_M_IMM), 4'h0, 8'h7C});
    check(16'(res.dst_sel), 16'h0003);
    run(16'h0030, 32'hDD21_CDAB, 4, 0);
    check(16'(res.mode), 16'(OAU_M_IMMX));
    check(res.data16, 16'hABCD);
    check(16'(res.idx_sel), 16'h0000);
    run(16'h0040, 32'h0011_EFBE, 3, 1);
    check(res.data16, 16'hBEEF);
    check(16'(res.pair_sel), 16'h0001);
    $display("done immediate");
  endtask

  task automatic t_direct;
    run(16'h0050, 32'h00C3_7703, 3, 0);
    check(16'(res.mode), 16'(OAU_M_DIR));
    check({15'h0000, res.load_pc}, 16'h0001);
    check(res.new_pc, 16'h0377);
    run(16'h0060, 32'h003A_3412, 3, 2);
    check({14'h0000, res.addr_valid, res.load_pc}, 16'h0002);
    check(res.addr, 16'h1234);
    run(16'h0070, 32'h00CD_0080, 3, 0);
    check({15'h0000, res.load_pc}, 16'h0001);
    check(res.new_pc, 16'h8000);
    $display("done direct");
  endtask

  task automatic t_indirect;
    run(16'h0080, 32'h0000_0086, 1, 0);
    check(16'(res.mode), 16'(OAU_M_IND));
    check(res.addr, 16'h0254);
    check({13'h0000, res.dst_sel}, 16'h0007);
    check(16'(res.pair_sel), 16'h0002);
    @(negedge clk);
    ptr_pair = 16'hFFFF;
    run(16'h0081, 32'h0000_0086, 1, 0);
    check(res.addr, 16'hFFFF);
    run(16'h0082, 32'h0000_001A, 1, 0);
    check(res.addr, 16'h2222);
    check(16'(res.pair_sel), 16'h0001);
    $display("done indirect");
  endtask

  task automatic t_indexed;
    run(16'h0090, 32'h00FD_3420, 3, 0);
    check(16'(res.mode), 16'(OAU_M_IDX));
    check(res.addr, 16'h1020);
    check(16'(res.idx_sel), 16'h0001);
    run(16'h00A0, 32'h00DD_34F0, 3, 0);
    check(res.addr, 16'h1FF0);
    check(16'(res.idx_sel), 16'h0000);
    $display("done indexed");
  endtask

  task automatic t_relative;
    run(16'h0040, 32'h0000_1805, 2, 0);
    check(16'(res.mode), 16'(OAU_M_REL));
    check(res.new_pc, 16'h0047);
    run(16'h0080, 32'h0000_18FE, 2, 1);
    check(res.new_pc, 16'h0080);
    run(16'h0001, 32'h0000_1880, 2, 0);
    check(res.new_pc, 16'hFF83);
    $display("done relative");
  endtask

  task automatic t_restart;
    for (int t = 0; t < 8; t++) begin
      run(16'h0100, {24'h000000, 2'h3, 3'(t), 3'h7}, 1, 0);
      check(16'(res.mode), 16'(OAU_M_PAGE0));
      check(res.new_pc, 16'(t * 8));
    end
    $display("done restart");
  endtask

  task automatic t_bit;
    run(16'h0110, 32'h0000_CBD5, 2, 0);
    check(16'(res.mode), 16'(OAU_M_BIT));
    check(16'({res.bit_sel, 1'b0, res.src_sel}), 16'h0025);
    run(16'h0114, 32'h0000_CB46, 2, 0);
    check(16'({res.bit_sel, 1'b0, res.src_sel}), 16'h0006);
    check({14'h0000, res.addr_valid, 1'b0}, 16'h0002);
    check(res.addr, ptr_pair);
    run(16'h0120, 32'hFDCB_05D6, 4, 0);
    check({14'h0000, res.addr_valid, 1'b0}, 16'h0002);
    check(res.addr, 16'h1005);
    $display("done bit");
  endtask

  // reset in mid-instruction must drop the half-taken jump
  task automatic t_reset;
    i_oau_prog_mem.mem[16'h0130] = 8'hC3;
    i_oau_prog_mem.fetch(16'h0130, 1, 0);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    check({dec_out.valid, dec_out.addr_valid, dec_out.load_pc, 9'h000, dec_out.mode}, 16'h0000);
    check(dec_out.new_pc, 16'h0000);
    rst_b = 1'b1;
    run(16'h0131, 32'h0000_0041, 1, 0);
    check(16'(res.mode), 16'(OAU_M_REG));
    $display("done reset");
  endtask

  // ------------------------------------------------------------
  // sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    check({dec_out.valid, 11'h000, dec_out.mode}, 16'h0000);
    rst_b = 1'b1;
    t_register();
    t_immediate();
    t_direct();
    t_indirect();
    t_indexed();
    t_relative();
    t_restart();
    t_bit();
    t_reset();
    final_report();
  end

  // whole run needs about 130 cycles; allow about fifteen times that
  initial begin
    #50000;
    failures++;
    final_report();
  end
endmodule
